// file: design/orc_edge_track.sv
// Purpose: per-bit edge detector on received control bytes
// Assumes: upd marks a new byte from the bus on the same clock
// Notes: rise and fall are one-cycle pulses per update
`timescale 1ns/1ns
`default_nettype none
module orc_edge_track (
	// Clock and reset
	input  wire logic       clk,
	input  wire logic       rst,
	// Received byte
	input  wire logic       upd,
	input  wire logic [7:0] data,
	// Edge pulses
	output logic      [7:0] rise,
	output logic      [7:0] fall
);
	logic [7:0] prev;

	always_ff @(posedge clk) begin
		if (rst) begin
			prev <= 8'h00;
		end else if (upd) begin
			prev <= data;
		end
	end

	genvar i;
	generate
		for (i = 0; i < 8; i++) begin : g_bit
			always_comb begin
				rise[i] = upd && data[i] && !prev[i];
				fall[i] = upd && !data[i] && prev[i];
			end
		end
	endgenerate
endmodule
`default_nettype wire

// file: design/orc_top.sv
// Purpose: overload relay trip and acknowledge control of a soft starter
// Assumes: host byte and breaker data arrive on the clk domain
// Notes: outputs are input bytes 1..3 fields and a run enable
// Summary of operation
// - Byte 2 reports relative current, 0..255 %
// - Byte 3 reports breaker thermal image
// - Trip at 110 %, 100 % with unbalance
// - Unbalance trip raises image 100 to 110
// - Control byte: run, trip, enable, auto
// - Run falling 1 to 0 acknowledges fault
// - Remote trip raises external fault, stops starter with param set
// - Remote trip shows reason code 6 continuously
// - Trip and relay bits only profiles 1-9
// - Relay stops starter at 110 % image
// - Relay works only with auto selector
// - Disable during relay trip keeps code 5
// - Link fault or switch-on disables breaker relay
// - Relay enable must be refreshed cyclically
// - Unbalance switch-off clears below 100 %
// - Ack needed at 110 % in manual mode
// - Code 5 while image at least 110 %
// - Ack by clearing per-profile run bit
// - Auto mode bit clears ack needed
// - Relay disable only below 100 %
// - Switch-on blocked until ack and below 100
// - Auto mode ready below 100 %, no ack
// - Code 5 clears below 100; 6 remote
`timescale 1ns/1ns
`default_nettype none
`include "orc_defines.svh"
module orc_top (
	// Clock and reset
	input  wire logic       clk,
	input  wire logic       rst,
	// Host control byte write
	input  wire logic       host_wr,
	input  wire logic [3:0] host_addr,
	input  wire logic [7:0] host_control_byte,
	// Extra control bytes for profiles 4-9
	input  wire logic [7:0] extra_ctrl_byte,
	input  wire logic [3:0] profile,
	// Breaker data
	input  wire logic [7:0] breaker_current,
	input  wire logic [7:0] breaker_heat,
	input  wire logic       phase_unbalance,
	input  wire logic       breaker_link_ok,
	input  wire logic       selector_auto,
	// Starter status
	input  wire logic       starter_switch_on,
	input  wire logic       external_fault_response_param,
	// Reported bytes
	output logic      [7:0] relative_current,
	output logic      [7:0] motor_heat_image,
	output logic      [2:0] trip_reason,
	output logic            acknowledge_needed,
	// Starter and breaker control
	output logic            starter_run,
	output logic            external_fault,
	output logic            breaker_relay_enable
);
	import orc_pkg::*;

	logic [7:0] ctrl;
	logic [7:0] host_masked;
	logic       upd;
	logic [7:0] rise;
	logic [7:0] fall;
	logic [7:0] erise;
	logic [7:0] efall;
	logic [13:0] refresh_cnt;
	logic       relay_fresh;
	logic       relay_active;
	logic       relay_trip;
	logic       remote_trip;
	logic       unbal_trip;
	logic       next_relay_trip;
	logic       prof_ok;
	logic       run_cmd;
	logic       run_fall;
	logic       hot;
	logic       warm;
	logic       auto_mode;
	orc_group_t grp;

	assign upd = host_wr && (host_addr == `ORC_OFS_HOST_CTRL);
	// Bits 4-7 are unused and ignored
	assign host_masked = {4'h0, host_control_byte[3:0]};

	orc_edge_track u_host (
		.clk  (clk),
		.rst  (rst),
		.upd  (upd),
		.data (host_masked),
		.rise (rise),
		.fall (fall)
	);

	orc_edge_track u_extra (
		.clk  (clk),
		.rst  (rst),
		.upd  (host_wr),
		.data (extra_ctrl_byte),
		.rise (erise),
		.fall (efall)
	);

	always_ff @(posedge clk) begin
		if (rst) begin
			ctrl <= 8'h00;
		end else if (upd) begin
			ctrl <= host_masked;
		end
	end

	always_comb begin
		prof_ok = (profile >= `ORC_PROF_MIN) &&
			(profile <= `ORC_PROF_MAX);
		if (profile <= `ORC_PROF_BASIC_MAX) begin
			grp = ORC_GRP_BASIC;
		end else if (profile <= `ORC_PROF_SHORT_MAX) begin
			grp = ORC_GRP_SHORT;
		end else if (profile <= `ORC_PROF_MAX) begin
			grp = ORC_GRP_LONG;
		end else begin
			grp = ORC_GRP_NONE;
		end
	end

	// Run bit and its acknowledging fall, per profile group
	always_comb begin
		unique case (grp)
		ORC_GRP_BASIC: begin
			run_cmd  = ctrl[`ORC_BIT_RUN];
			run_fall = fall[`ORC_BIT_RUN];
		end
		ORC_GRP_SHORT: begin
			run_cmd  = extra_ctrl_byte[`ORC_BIT_RUN_SHORT];
			run_fall = efall[`ORC_BIT_RUN_SHORT];
		end
		ORC_GRP_LONG: begin
			run_cmd  = extra_ctrl_byte[`ORC_BIT_RUN_LONG];
			run_fall = efall[`ORC_BIT_RUN_LONG];
		end
		ORC_GRP_NONE: begin
			run_cmd  = extra_ctrl_byte[0];
			run_fall = 1'b0;
		end
		endcase
	end

	assign hot  = breaker_heat >= `ORC_PCT_TRIP;
	assign warm = breaker_heat >= `ORC_PCT_LOW;
	assign auto_mode = ctrl[`ORC_BIT_AUTO];

	// Enable must be rewritten within the refresh window
	always_ff @(posedge clk) begin
		if (rst) begin
			refresh_cnt <= 14'h0000;
		end else if (upd && host_control_byte[`ORC_BIT_RELAY_EN]) begin
			refresh_cnt <= 14'(`ORC_REFRESH_CYC);
		end else if (refresh_cnt != 14'h0000) begin
			refresh_cnt <= refresh_cnt - 14'h0001;
		end
	end

	assign relay_fresh = (refresh_cnt != 14'h0000) &&
		ctrl[`ORC_BIT_RELAY_EN];
	// Disable is held off while image is 100 % or more
	always_ff @(posedge clk) begin
		if (rst) begin
			relay_active <= 1'b0;
		end else if (!prof_ok || !selector_auto) begin
			relay_active <= 1'b0;
		end else if (relay_fresh) begin
			relay_active <= 1'b1;
		end else if (!warm) begin
			relay_active <= 1'b0;
		end
	end

	always_comb begin
		next_relay_trip = relay_trip;
		if (relay_active && hot) begin
			next_relay_trip = 1'b1;
		end else if (!warm) begin
			next_relay_trip = 1'b0;
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			relay_trip <= 1'b0;
		end else begin
			relay_trip <= next_relay_trip;
		end
	end

	// Breaker-side trip under unbalance at 100 %
	always_ff @(posedge clk) begin
		if (rst) begin
			unbal_trip <= 1'b0;
		end else if (phase_unbalance && warm) begin
			unbal_trip <= 1'b1;
		end else if (!warm) begin
			unbal_trip <= 1'b0;
		end
	end

	// Remote trip: set on rising edge, cleared by run fall
	always_ff @(posedge clk) begin
		if (rst) begin
			remote_trip <= 1'b0;
		end else if (prof_ok && rise[`ORC_BIT_RTRIP]) begin
			remote_trip <= 1'b1;
		end else if (run_fall) begin
			remote_trip <= 1'b0;
		end
	end

	assign external_fault = remote_trip;

	// Set wins over clear
	always_ff @(posedge clk) begin
		if (rst) begin
			acknowledge_needed <= 1'b0;
		end else if (relay_active && hot && !auto_mode) begin
			acknowledge_needed <= 1'b1;
		end else if (auto_mode || run_fall) begin
			acknowledge_needed <= 1'b0;
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			trip_reason <= `ORC_TRIP_NONE;
		end else if (remote_trip) begin
			trip_reason <= `ORC_TRIP_REMOTE;
		end else if (next_relay_trip) begin
			trip_reason <= `ORC_TRIP_RELAY;
		end else if (unbal_trip) begin
			trip_reason <= `ORC_TRIP_UNBAL;
		end else begin
			trip_reason <= `ORC_TRIP_NONE;
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			relative_current <= 8'h00;
			motor_heat_image <= 8'h00;
		end else begin
			relative_current <= breaker_current;
			if (unbal_trip && warm && !hot) begin
				motor_heat_image <= `ORC_PCT_TRIP;
			end else begin
				motor_heat_image <= breaker_heat;
			end
		end
	end

	// Run enable: blocked by relay or unbalance trip, remote trip with param set, or pending ack
	always_ff @(posedge clk) begin
		if (rst) begin
			starter_run <= 1'b0;
		end else if (remote_trip && external_fault_response_param) begin
			starter_run <= 1'b0;
		end else if (next_relay_trip || unbal_trip) begin
			starter_run <= 1'b0;
		end else if (acknowledge_needed) begin
			starter_run <= 1'b0;
		end else begin
			starter_run <= run_cmd;
		end
	end

	// Breaker relay off on link fault or starter switch-on
	always_ff @(posedge clk) begin
		if (rst) begin
			breaker_relay_enable <= 1'b0;
		end else if (!breaker_link_ok || starter_switch_on) begin
			breaker_relay_enable <= 1'b0;
		end else begin
			breaker_relay_enable <= relay_active;
		end
	end

	a_relay_trip_hot: assert property (@(posedge clk)
		disable iff (rst) relay_active && hot |=>
		trip_reason == `ORC_TRIP_RELAY || remote_trip)
		else $error("relay trip not reported");
	a_trip_clear: assert property (@(posedge clk)
		disable iff (rst) !warm && !remote_trip && !unbal_trip ##1 !warm
		|-> trip_reason == `ORC_TRIP_NONE)
		else $error("trip code not cleared");
	a_ack_set: assert property (@(posedge clk)
		disable iff (rst) relay_active && hot && !auto_mode |=>
		acknowledge_needed)
		else $error("ack not set");
	a_ack_auto: assert property (@(posedge clk)
		disable iff (rst) auto_mode && !(relay_active && hot) |=>
		!acknowledge_needed)
		else $error("ack not cleared by auto");
	a_block_run: assert property (@(posedge clk)
		disable iff (rst) acknowledge_needed |=> !starter_run)
		else $error("run while ack needed");
	a_remote_code: assert property (@(posedge clk)
		disable iff (rst) remote_trip |=> trip_reason == `ORC_TRIP_REMOTE)
		else $error("remote code missing");
	a_remote_edge: assert property (@(posedge clk)
		disable iff (rst) prof_ok && rise[`ORC_BIT_RTRIP] |=> external_fault)
		else $error("remote edge lost");
	a_breaker_off: assert property (@(posedge clk)
		disable iff (rst) !breaker_link_ok |=> !breaker_relay_enable)
		else $error("breaker relay left on");
	a_no_profile: assert property (@(posedge clk)
		disable iff (rst) !prof_ok |=> !relay_active)
		else $error("relay active outside profiles");
	c_relay_trip: cover property (@(posedge clk) relay_trip);
	c_remote: cover property (@(posedge clk) remote_trip);
	c_ack_run: cover property (@(posedge clk)
		acknowledge_needed ##1 !acknowledge_needed);
endmodule
`default_nettype wire

// file: inc/orc_defines.svh
// Purpose: constants for the overload relay trip control block
// Assumes: percentages are unsigned bytes, 1 LSB = 1 %
// Notes: refresh window is a cycle count of the bus clock
`ifndef ORC_DEFINES_SVH
`define ORC_DEFINES_SVH
`define ORC_OFS_HOST_CTRL     4'h0
`define ORC_BIT_RUN           0
`define ORC_BIT_RTRIP         1
`define ORC_BIT_RELAY_EN      2
`define ORC_BIT_AUTO          3
`define ORC_BIT_RUN_SHORT     0
`define ORC_BIT_RUN_LONG      6
`define ORC_PCT_TRIP          8'h6E
`define ORC_PCT_LOW           8'h64
`define ORC_TRIP_NONE         3'h0
`define ORC_TRIP_UNBAL        3'h3
`define ORC_TRIP_RELAY        3'h5
`define ORC_TRIP_REMOTE       3'h6
`define ORC_REFRESH_US        100
`define ORC_CLK_MHZ           100
`define ORC_REFRESH_CYC       (`ORC_REFRESH_US * `ORC_CLK_MHZ)
`define ORC_PROF_MIN          4'h1
`define ORC_PROF_MAX          4'h9
`define ORC_PROF_BASIC_MAX    4'h3
`define ORC_PROF_SHORT_MAX    4'h6
`endif

// file: inc/orc_pkg.sv
// Purpose: types for the overload relay trip control block
// Assumes: nothing beyond the defines header
// Notes: profile groups select the acknowledge bit
package orc_pkg;
	typedef enum logic [1:0] {
		ORC_GRP_BASIC,
		ORC_GRP_SHORT,
		ORC_GRP_LONG,
		ORC_GRP_NONE
	} orc_group_t;
	typedef enum logic [1:0] {
		ORC_ST_IDLE,
		ORC_ST_TRIPPED,
		ORC_ST_REMOTE
	} orc_state_t;
endpackage

// file: tb/orc_breaker_model.sv
// Purpose: breaker side of the relay control, slow thermal image
// Assumes: bench sets goals, model ramps one percent per clock
// Notes: current follows its goal one clock later
`timescale 1ns/1ns
`default_nettype none
module orc_breaker_model (
	// Clock
	input  wire logic       clk,
	// Goals from bench
	input  wire logic [7:0] heat_goal,
	input  wire logic [7:0] cur_goal,
	// Starter side
	input  wire logic       external_fault,
	input  wire logic       starter_run,
	// Breaker data
	output logic      [7:0] breaker_current,
	output logic      [7:0] breaker_heat,
	output logic            breaker_open
);
	initial begin
		breaker_heat = 8'h00;
		breaker_current = 8'h00;
		breaker_open = 1'b0;
	end
	// Starter ignoring an external fault: breaker opens by itself
	always @(posedge clk) begin
		breaker_open <= external_fault && (breaker_open || starter_run);
	end
	// Image moves gradually, like a real thermal model
	always @(posedge clk) begin
		breaker_current <= cur_goal;
		if (breaker_heat < heat_goal)
			breaker_heat <= breaker_heat + 8'h01;
		else if (breaker_heat > heat_goal)
			breaker_heat <= breaker_heat - 8'h01;
	end
endmodule
`default_nettype wire

// file: tb/tb_orc_top.sv
// Purpose: self-checking bench of the relay trip control
// Assumes: one scenario lets the refresh window lapse
// Notes: outputs sampled three cycles after each write
`timescale 1ns/1ns
`default_nettype none
module tb_orc_top;
	logic clk, rst, host_wr, unb, link_ok, sel_auto, sw_on, param;
	logic [3:0] host_addr, profile;
	logic [7:0] ctrl, extra, heat_goal, cur_goal, cur, heat;
	logic [7:0] rel_cur, image;
	logic [2:0] trip;
	logic ack, run, ext_fault, relay_en, brk_open;
	int failures = 0;
	int samples_checked = 0;

	orc_breaker_model model (.clk(clk), .heat_goal(heat_goal),
		.cur_goal(cur_goal), .external_fault(ext_fault),
		.starter_run(run), .breaker_current(cur), .breaker_heat(heat),
		.breaker_open(brk_open));
	orc_top dut (.clk(clk), .rst(rst), .host_wr(host_wr),
		.host_addr(host_addr), .host_control_byte(ctrl),
		.extra_ctrl_byte(extra), .profile(profile),
		.breaker_current(cur), .breaker_heat(heat),
		.phase_unbalance(unb), .breaker_link_ok(link_ok),
		.selector_auto(sel_auto), .starter_switch_on(sw_on),
		.external_fault_response_param(param),
		.relative_current(rel_cur), .motor_heat_image(image),
		.trip_reason(trip), .acknowledge_needed(ack),
		.starter_run(run), .external_fault(ext_fault),
		.breaker_relay_enable(relay_en));

	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end

	task automatic tick(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask

	task automatic check(input logic [7:0] seen, input logic [7:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			failures++;
			$display("Error at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic final_report();
		$display("checked %0d failures %0d", samples_checked, failures);
		if (failures == 0 && samples_checked > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask

	task automatic write(input logic [7:0] b);
		host_wr = 1'b1;
		host_addr = 4'h0;
		ctrl = b;
		tick(1);
		host_wr = 1'b0;
		tick(3);
	endtask

	task automatic heat_to(input logic [7:0] v);
		int i;
		heat_goal = v;
		for (i = 0; i < 400 && heat !== v; i++)
			tick(1);
		if (heat !== v) begin
			failures++;
			final_report();
		end
		tick(3);
	endtask

	task automatic t_levels();
		cur_goal = 8'hFF;
		heat_to(8'h40);
		check(rel_cur, 8'hFF);
		check(image, 8'h40);
	endtask

	task automatic t_remote();
		write(8'hF1);
		write(8'hF3);
		check(ext_fault, 1);
		check(run, 0);
		tick(20);
		check(trip, 3'h6);
		write(8'h01);
		write(8'h00);
		check(ext_fault, 0);
	endtask

	task automatic t_manual();
		write(8'h05);
		heat_to(8'h6E);
		check(trip, 3'h5);
		check(ack, 1);
		check(run, 0);
		heat_to(8'h63);
		check(ack, 1);
		check(run, 0);
		check(trip, 3'h0);
		write(8'h0D);
		write(8'h05);
		check(ack, 0);
		check(run, 1);
	endtask

	task automatic t_unbalance();
		unb = 1'b1;
		heat_to(8'h64);
		check(run, 0);
		check(trip, 3'h3);
		check(image, 8'h6E);
		unb = 1'b0;
		heat_to(8'h50);
		check(trip, 3'h0);
		write(8'h0D);
		write(8'h05);
		check(run, 1);
	endtask

	task automatic t_auto();
		write(8'h0D);
		heat_to(8'h6E);
		check(run, 0);
		check(ack, 0);
		heat_to(8'h50);
		check(run, 1);
	endtask

	task automatic t_profiles();
		profile = 4'h4;
		extra = 8'h01;
		write(8'h04);
		heat_to(8'h6E);
		check(ack, 1);
		heat_to(8'h50);
		extra = 8'h00;
		write(8'h04);
		check(ack, 0);
		profile = 4'hA;
		write(8'h00);
		write(8'h02);
		check(ext_fault, 0);
	endtask

	task automatic t_ignore();
		profile = 4'h1;
		param = 1'b0;
		write(8'h01);
		write(8'h03);
		check(ext_fault, 1);
		check(run, 1);
		check(brk_open, 1);
		write(8'h01);
		write(8'h00);
		check(brk_open, 0);
		param = 1'b1;
	endtask

	task automatic t_relay_hold();
		write(8'h04);
		check(relay_en, 1);
		sw_on = 1'b1;
		tick(3);
		check(relay_en, 0);
		sw_on = 1'b0;
		link_ok = 1'b0;
		tick(3);
		check(relay_en, 0);
		link_ok = 1'b1;
		sel_auto = 1'b0;
		tick(3);
		check(relay_en, 0);
		sel_auto = 1'b1;
		tick(3);
		check(relay_en, 1);
		heat_to(8'h6E);
		write(8'h00);
		check(trip, 3'h5);
		check(relay_en, 1);
		heat_to(8'h63);
		check(relay_en, 0);
		check(trip, 3'h0);
		write(8'h08);
		write(8'h00);
		check(ack, 0);
	endtask

	task automatic t_refresh();
		write(8'h04);
		tick(9990);
		check(relay_en, 1);
		tick(20);
		check(relay_en, 0);
	endtask

	initial begin
		rst = 1'b1;
		host_wr = 1'b0;
		host_addr = 4'h0;
		ctrl = 8'h00;
		extra = 8'h00;
		profile = 4'h1;
		heat_goal = 8'h00;
		cur_goal = 8'h00;
		unb = 1'b0;
		link_ok = 1'b1;
		sel_auto = 1'b1;
		sw_on = 1'b0;
		param = 1'b1;
		tick(6);
		rst = 1'b0;
		tick(1);
		check(ext_fault, 0);
		t_levels();
		t_remote();
		t_manual();
		t_unbalance();
		t_auto();
		t_profiles();
		t_ignore();
		t_relay_hold();
		t_refresh();
		final_report();
	end
endmodule
`default_nettype wire
